// ### src/rarsp_pkg.sv
// rarsp_pkg: constants, types and register map of the alarm register block
// and of its 4-wire serial port.
// assumes: used by rarsp_alarm_port and rarsp_sync; nothing imported.

package rarsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses (4-bit address pointer space)
  localparam logic [3:0] ADDR_WK_MIN   = 4'h8;  // weekly alarm minute
  localparam logic [3:0] ADDR_WK_HOUR  = 4'h9;  // weekly alarm hour
  localparam logic [3:0] ADDR_DAY_MASK = 4'ha;  // weekly alarm day mask
  localparam logic [3:0] ADDR_DY_MIN   = 4'hb;  // daily alarm minute
  localparam logic [3:0] ADDR_DY_HOUR  = 4'hc;  // daily alarm hour

  ////////////////////////////////////////////////////////////////////////////
  // field widths (fields sit at bit 0, higher bits read zero)
  localparam int MASK_W = 7;                    // day mask bits 6..0
  localparam int MIN_W  = 7;                    // bcd minute bits 6..0
  localparam int HOUR_W = 6;                    // bcd hour bits 5..0
  localparam int DAY_W  = 3;                    // weekday counter width
  localparam int HOUR_MERIDIEM_BIT = 5;         // pm flag or weight-20 bit

  // reset values of the alarm fields
  localparam logic [MASK_W-1:0] RST_DAY_MASK = 7'h00;  // no day enabled
  localparam logic [MIN_W-1:0]  RST_MIN      = 7'h00;  // minute 00
  localparam logic [HOUR_W-1:0] RST_HOUR     = 6'h00;  // hour 00

  ////////////////////////////////////////////////////////////////////////////
  // transfer format nibble
  localparam logic [3:0] FMT_WR_SINGLE = 4'h8;  // one byte write
  localparam logic [3:0] FMT_WR_BURST  = 4'h0;  // burst write
  localparam logic [3:0] FMT_RD_SINGLE = 4'hc;  // one byte read
  localparam logic [3:0] FMT_RD_BURST  = 4'h4;  // burst read
  localparam int FMT_SINGLE_BIT = 3;            // 1: single byte
  localparam int FMT_READ_BIT   = 2;            // 1: read

  // byte framing
  localparam logic [2:0] LAST_BIT = 3'h7;       // bit index of 8th bit
  localparam logic [2:0] FIRST_BIT = 3'h0;      // fresh bit counter
  localparam int SYNC_W = 3;                    // ce, sclk, si

  ////////////////////////////////////////////////////////////////////////////
  // serial engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,                           // chip enable low
    ST_CMD  = 3'b010,                           // shifting command byte
    ST_DATA = 3'b100                            // shifting data bytes
  } rarsp_state_e;

  // stored alarm settings
  typedef struct packed {
    logic [MIN_W-1:0]  wk_min;                  // weekly minute
    logic [HOUR_W-1:0] wk_hour;                 // weekly hour
    logic [MASK_W-1:0] day_mask;                // weekly day enables
    logic [MIN_W-1:0]  dy_min;                  // daily minute
    logic [HOUR_W-1:0] dy_hour;                 // daily hour
  } rarsp_alarm_s;

  // current time from the counters
  typedef struct packed {
    logic [DAY_W-1:0]  day;                     // weekday code
    logic [HOUR_W-1:0] hour;                    // bcd hour
    logic [MIN_W-1:0]  minute;                  // bcd minute
  } rarsp_time_s;

endpackage

// ### src/rarsp_sync.sv
// rarsp_sync: two-flop synchronisers for the serial port pins.
// assumes: pins are asynchronous to mclk; first stage read only by second.

`timescale 1ns/10ps

module rarsp_sync (
  input  wire logic                        mclk,    // system clock
  input  wire logic                        resetn,  // async reset, low
  input  wire logic                        clk_en,  // freezes state when low
  input  wire logic [rarsp_pkg::SYNC_W-1:0] pin_in,  // raw pin levels
  output logic      [rarsp_pkg::SYNC_W-1:0] pin_out  // synchronised levels
);

  ////////////////////////////////////////////////////////////////////////////
  // one synchroniser pair per pin
  genvar g;
  generate
    for (g = 0; g < rarsp_pkg::SYNC_W; g++)
    begin : g_bit
      logic stage1;                             // metastable stage
      logic stage2;                             // clean stage
      // two flip-flops, first read only by second
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
        begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end
        else if (clk_en)
        begin
          stage1 <= pin_in[g];
          stage2 <= stage1;
        end
      end
      assign pin_out[g] = stage2;
    end
  endgenerate

endmodule

// ### src/rarsp_alarm_port.sv
// rarsp_alarm_port: alarm registers of the clock with their 4-wire serial
// port (chip enable, serial clock, serial in, serial out) and alarm compare.
// assumes: pins arrive asynchronously; current time comes from counters on
// mclk; only the alarm addresses are mapped here, others read zero.
//
// Notes on behaviour
// RQ1: day mask holds bits 6..0, bit 7 zero
// RQ2: mask bit n enables weekday code n
// RQ3: empty day mask never gives weekly match
// RQ4: weekly hour bit 5 is pm or 20
// RQ5: daily hour bit 5 is pm or 20
// RQ6: twelve-hour midnight is 12, noon 32
// RQ7: daily minute bcd bits 6..0, bit 7 zero
// RQ8: daily hour bits 5..0, bits 7,6 zero
// RQ9: host programs only real hour and minute
// RQ10: alarm fields undefined at power-up, high bits zero
// RQ11: sclk low at ce rise: out rise, in fall
// RQ12: sclk high at ce rise: out fall, in rise
// RQ13: session spans one chip enable high interval
// RQ14: data moves in whole eight-bit bytes
// RQ15: command upper nibble loads address pointer
// RQ16: command lower nibble loads transfer format
// RQ17: every byte shifts most significant bit first
// RQ18: single and burst formats, read and write
// RQ19: formats 8h, 0h, Ch, 4h
// RQ20: burst pointer increments, wraps Fh to 0h
// RQ21: weekly needs day, hour, minute; daily hour, minute
// RQ22: chip enable fall drops partial byte, clears count

`timescale 1ns/10ps

module rarsp_alarm_port (
  input  wire logic                   mclk,          // 100 MHz clock
  input  wire logic                   resetn,        // async reset, low
  input  wire logic                   clk_en,        // freezes state when low
  input  wire logic                   ce,            // chip enable pin
  input  wire logic                   sclk,          // serial clock pin
  input  wire logic                   si,            // serial data in pin
  input  wire rarsp_pkg::rarsp_time_s cur_time,      // current day/hour/min
  output logic                        so,            // serial data out
  output logic                        so_oe,         // serial out enable
  output logic                        weekly_match,  // weekly alarm hit
  output logic                        daily_match    // daily alarm hit
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge detection
  logic [rarsp_pkg::SYNC_W-1:0] pins_s;          // synchronised pins
  logic                         ce_s;            // chip enable, synced
  logic                         sclk_s;          // serial clock, synced
  logic                         si_s;            // serial in, synced
  logic                         ce_d;            // chip enable, last cycle
  logic                         sclk_d;          // serial clock, last cycle
  logic                         next_ce_d;       // next chip enable history
  logic                         next_sclk_d;     // next clock history

  rarsp_sync u_sync (
    .mclk    (mclk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .pin_in  ({ce, sclk, si}),
    .pin_out (pins_s)
  );

  assign ce_s   = pins_s[2];
  assign sclk_s = pins_s[1];
  assign si_s   = pins_s[0];

  // history of synced levels for edge finding
  always_comb
  begin
    next_ce_d   = ce_s;
    next_sclk_d = sclk_s;
  end

  // history registers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ce_d   <= 1'b0;
      sclk_d <= 1'b0;
    end
    else if (clk_en)
    begin
      ce_d   <= next_ce_d;
      sclk_d <= next_sclk_d;
    end
  end

  logic ce_rise;                                  // session start
  logic ce_fall;                                  // session end
  logic sclk_rise;                                // serial clock rise
  logic sclk_fall;                                // serial clock fall
  logic pol_hi;                                   // clock was high at start
  logic sample_edge;                              // edge that takes si
  logic drive_edge;                               // edge that moves so

  assign ce_rise     = ce_s & ~ce_d;
  assign ce_fall     = ~ce_s & ce_d;
  assign sclk_rise   = sclk_s & ~sclk_d;
  assign sclk_fall   = ~sclk_s & sclk_d;
  assign sample_edge = pol_hi ? sclk_rise : sclk_fall;  // RQ11 RQ12
  assign drive_edge  = pol_hi ? sclk_fall : sclk_rise;  // RQ11 RQ12

  ////////////////////////////////////////////////////////////////////////////
  // alarm register readback
  rarsp_pkg::rarsp_alarm_s alarm;                 // stored settings

  // byte seen by the host at an address, unused bits zero
  function automatic logic [7:0] read_byte(input logic [3:0] a,
                                           input rarsp_pkg::rarsp_alarm_s r);
    logic [7:0] b;
    b = 8'h00;
    case (a)
      rarsp_pkg::ADDR_WK_MIN:   b = {1'b0, r.wk_min};
      rarsp_pkg::ADDR_WK_HOUR:  b = {2'b00, r.wk_hour};
      rarsp_pkg::ADDR_DAY_MASK: b = {1'b0, r.day_mask};  // RQ1
      rarsp_pkg::ADDR_DY_MIN:   b = {1'b0, r.dy_min};    // RQ7
      rarsp_pkg::ADDR_DY_HOUR:  b = {2'b00, r.dy_hour};  // RQ8
      default:                  b = 8'h00;               // unmapped here
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // serial engine
  rarsp_pkg::rarsp_state_e state;                 // engine state
  rarsp_pkg::rarsp_state_e next_state;            // next engine state
  logic                    next_pol_hi;           // next polarity
  logic [2:0]              bit_cnt;               // bits of current byte
  logic [2:0]              next_bit_cnt;          // next bit count
  logic [7:0]              rx_sr;                 // receive shifter
  logic [7:0]              next_rx_sr;            // next receive shifter
  logic [7:0]              tx_sr;                 // transmit shifter
  logic [7:0]              next_tx_sr;            // next transmit shifter
  logic [3:0]              addr_ptr;              // address pointer
  logic [3:0]              next_addr_ptr;         // next address pointer
  logic [3:0]              fmt;                   // transfer format
  logic [3:0]              next_fmt;              // next transfer format
  logic                    next_so;               // next serial out
  logic                    next_so_oe;            // next out enable
  logic                    wr_en;                 // write strobe
  logic [3:0]              wr_addr;               // write address
  logic [7:0]              wr_data;               // write byte
  logic                    is_read;               // read format active
  logic                    is_single;             // single-byte format

  assign is_read   = fmt[rarsp_pkg::FMT_READ_BIT];    // RQ19
  assign is_single = fmt[rarsp_pkg::FMT_SINGLE_BIT];  // RQ19

  // next state of the engine
  always_comb
  begin
    next_state    = state;
    next_pol_hi   = pol_hi;
    next_bit_cnt  = bit_cnt;
    next_rx_sr    = rx_sr;
    next_tx_sr    = tx_sr;
    next_addr_ptr = addr_ptr;
    next_fmt      = fmt;
    next_so       = so;
    next_so_oe    = so_oe;
    wr_en         = 1'b0;
    wr_addr       = addr_ptr;
    wr_data       = 8'h00;
    case (state)
      rarsp_pkg::ST_IDLE:
      begin
        // wait for session start, latch clock level
        if (ce_rise)
        begin
          next_state   = rarsp_pkg::ST_CMD;                 // RQ13
          next_pol_hi  = sclk_s;                            // RQ11 RQ12
          next_bit_cnt = rarsp_pkg::FIRST_BIT;
        end
      end
      rarsp_pkg::ST_CMD:
      begin
        if (ce_fall)
        begin
          // session over, partial byte dropped
          next_state   = rarsp_pkg::ST_IDLE;                // RQ13
          next_bit_cnt = rarsp_pkg::FIRST_BIT;              // RQ22
          next_so_oe   = 1'b0;
        end
        else if (sample_edge)
        begin
          next_rx_sr = {rx_sr[6:0], si_s};                  // RQ17
          if (bit_cnt == rarsp_pkg::LAST_BIT)
          begin
            // whole command byte in
            next_addr_ptr = next_rx_sr[7:4];                // RQ15
            next_fmt      = next_rx_sr[3:0];                // RQ16
            next_tx_sr    = read_byte(next_rx_sr[7:4], alarm);
            next_bit_cnt  = rarsp_pkg::FIRST_BIT;
            next_state    = rarsp_pkg::ST_DATA;             // RQ14
          end
          else
          begin
            next_bit_cnt = bit_cnt + 3'h1;
          end
        end
      end
      rarsp_pkg::ST_DATA:
      begin
        if (ce_fall)
        begin
          // session over, partial byte dropped
          next_state   = rarsp_pkg::ST_IDLE;                // RQ13
          next_bit_cnt = rarsp_pkg::FIRST_BIT;              // RQ22
          next_so_oe   = 1'b0;
        end
        else
        begin
          // read: present next bit on the drive edge
          if (drive_edge && is_read)
          begin
            next_so    = tx_sr[7];                          // RQ17
            next_tx_sr = {tx_sr[6:0], 1'b0};
            next_so_oe = 1'b1;
          end
          if (sample_edge)
          begin
            next_rx_sr = {rx_sr[6:0], si_s};                // RQ17
            if (bit_cnt == rarsp_pkg::LAST_BIT)
            begin
              next_bit_cnt = rarsp_pkg::FIRST_BIT;          // RQ14
              // write: commit the full byte only
              if (!is_read)
              begin
                wr_en   = 1'b1;
                wr_data = next_rx_sr;
              end
              if (is_single)
              begin
                // single byte: next byte is a new command
                next_state = rarsp_pkg::ST_CMD;             // RQ18
                next_so_oe = 1'b0;
              end
              else
              begin
                // burst: step pointer, wraps Fh to 0h
                next_addr_ptr = addr_ptr + 4'h1;            // RQ20
                next_tx_sr    = read_byte(next_addr_ptr, alarm);
              end
            end
            else
            begin
              next_bit_cnt = bit_cnt + 3'h1;
            end
          end
        end
      end
      default:
      begin
        next_state   = rarsp_pkg::ST_IDLE;
        next_bit_cnt = rarsp_pkg::FIRST_BIT;
        next_so_oe   = 1'b0;
      end
    endcase
  end

  // engine registers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state    <= rarsp_pkg::ST_IDLE;
      pol_hi   <= 1'b0;
      bit_cnt  <= rarsp_pkg::FIRST_BIT;
      rx_sr    <= 8'h00;
      tx_sr    <= 8'h00;
      addr_ptr <= 4'h0;
      fmt      <= 4'h0;
      so       <= 1'b0;
      so_oe    <= 1'b0;
    end
    else if (clk_en)
    begin
      state    <= next_state;
      pol_hi   <= next_pol_hi;
      bit_cnt  <= next_bit_cnt;
      rx_sr    <= next_rx_sr;
      tx_sr    <= next_tx_sr;
      addr_ptr <= next_addr_ptr;
      fmt      <= next_fmt;
      so       <= next_so;
      so_oe    <= next_so_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm registers
  rarsp_pkg::rarsp_alarm_s next_alarm;            // next stored settings

  // store only the defined field bits of a written byte
  always_comb
  begin
    next_alarm = alarm;
    if (wr_en)
    begin
      case (wr_addr)
        rarsp_pkg::ADDR_WK_MIN:   next_alarm.wk_min   = wr_data[6:0];
        rarsp_pkg::ADDR_WK_HOUR:  next_alarm.wk_hour  = wr_data[5:0];  // RQ4
        rarsp_pkg::ADDR_DAY_MASK: next_alarm.day_mask = wr_data[6:0];  // RQ1
        rarsp_pkg::ADDR_DY_MIN:   next_alarm.dy_min   = wr_data[6:0];  // RQ7
        rarsp_pkg::ADDR_DY_HOUR:  next_alarm.dy_hour  = wr_data[5:0];  // RQ5 RQ8
        default:                  next_alarm          = alarm;        // ignored
      endcase
    end
  end

  // settings registers; reset picks one of the undefined power-up values
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      alarm.wk_min   <= rarsp_pkg::RST_MIN;                 // RQ10
      alarm.wk_hour  <= rarsp_pkg::RST_HOUR;                // RQ10
      alarm.day_mask <= rarsp_pkg::RST_DAY_MASK;            // RQ10
      alarm.dy_min   <= rarsp_pkg::RST_MIN;                 // RQ10
      alarm.dy_hour  <= rarsp_pkg::RST_HOUR;                // RQ10
    end
    else if (clk_en)
    begin
      alarm <= next_alarm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm compare
  logic [rarsp_pkg::MASK_W-1:0] day_sel;          // one-hot current day
  logic                         day_hit;          // today enabled
  logic                         next_weekly;      // next weekly match
  logic                         next_daily;       // next daily match

  // weekday code n selects mask bit n; code 7 selects none
  genvar d;
  generate
    for (d = 0; d < rarsp_pkg::MASK_W; d++)
    begin : g_day
      assign day_sel[d] = (cur_time.day == 3'(d));  // RQ2
    end
  endgenerate

  assign day_hit = |(day_sel & alarm.day_mask);     // RQ2 RQ3

  // hour bit 5 compares raw: pm flag or weight 20, per counter mode;
  // twelve-hour codes 12 and 32 line up with the counter encoding
  always_comb
  begin
    next_weekly = day_hit
                  && (cur_time.hour == alarm.wk_hour)     // RQ4 RQ6
                  && (cur_time.minute == alarm.wk_min);   // RQ21
    next_daily  = (cur_time.hour == alarm.dy_hour)        // RQ5 RQ6
                  && (cur_time.minute == alarm.dy_min);   // RQ21
  end

  // match flags, level while time equals setting
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      weekly_match <= 1'b0;
      daily_match  <= 1'b0;
    end
    else if (clk_en)
    begin
      weekly_match <= next_weekly;
      daily_match  <= next_daily;
    end
  end

endmodule

// ### dv/rarsp_host_model.sv
// rarsp_host_model: host side of the 4-wire serial port, driven by tb tasks.
// assumes: mclk rises at 5 mod 10 ns, so pin changes here never meet it.
`timescale 1ns/10ps
module rarsp_host_model (
  output logic      ce,    // chip enable
  output logic      sclk,  // serial clock, still between sessions
  output logic      si,    // data to device
  input  wire logic so,    // data from device
  input  wire logic so_oe  // device drives so
);
  logic pol;  // sclk level at ce rise
  ////////////////////////////////////////////////////////////////////////
  // idle pins at time zero
  initial
  begin
    ce = 1'b0;
    sclk = 1'b0;
    si = 1'b0;
    pol = 1'b0;
  end
  // open a session, sclk level picks the edge pair
  task automatic open_s(input logic p);
    pol = p;
    sclk = p;
    #100 ce = 1'b1;
    #100;
  endtask
  // close a session, si no longer held so it flips
  task automatic close_s();
    #100 ce = 1'b0;
    si = ~si;
    #100;
  endtask
  // n bits msb first, 125 ns per bit
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      sclk = ~pol;  // drive edge
      si = tx[i];
      #62.5 rx[i] = so_oe ? so : ~so;  // undriven line reads inverted
      sclk = pol;  // sample edge
      #62.5;
    end
  endtask
endmodule

// ### dv/rarsp_checker_properties.sv
// rarsp_checker: port-level properties of the alarm register block.
// assumes: one clock domain; bound to rarsp_alarm_port below.
`timescale 1ns/10ps
module rarsp_checker (
  input wire logic                   mclk,          // system clock
  input wire logic                   resetn,        // async reset, low
  input wire logic                   clk_en,        // run enable
  input wire logic                   ce,            // chip enable pin
  input wire logic                   sclk,          // serial clock pin
  input wire logic                   si,            // serial data in
  input wire rarsp_pkg::rarsp_time_s cur_time,      // current time
  input wire logic                   so,            // serial data out
  input wire logic                   so_oe,         // out enable
  input wire logic                   weekly_match,  // weekly hit
  input wire logic                   daily_match    // daily hit
);
  logic [2:0] rdy_cnt;       // edges since reset or clk_en low, saturating
  logic [2:0] next_rdy_cnt;  // next count
  logic       pol;           // sclk level at ce rise
  logic       next_pol;      // next polarity
  logic       ce_q;          // ce one edge ago
  logic       rdy;           // reset long enough ago
  ////////////////////////////////////////////////////////////////////////
  // helper next values
  always_comb
  begin
    if (!clk_en)
      next_rdy_cnt = 3'h0;  // frozen design: restart settle count
    else
      next_rdy_cnt = (rdy_cnt == 3'h7) ? rdy_cnt : rdy_cnt + 3'h1;
    next_pol = (ce && !ce_q) ? sclk : pol;
  end
  // helper registers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdy_cnt <= 3'h0;
      pol <= 1'b0;
      ce_q <= 1'b0;
    end
    else
    begin
      rdy_cnt <= next_rdy_cnt;
      pol <= next_pol;
      ce_q <= ce;
    end
  end
  assign rdy = (rdy_cnt == 3'h7);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn || !clk_en);
  ////////////////////////////////////////////////////////////////////////
  sequence s_quiet;
    !ce [*8];
  endsequence
  property p_oe_idle;
    !ce [*5] |-> !so_oe;
  endproperty
  property p_oe_drop;
    $fell(ce) |-> ##[1:5] !so_oe;
  endproperty
  property p_oe_start;
    $rose(so_oe) |-> $past(ce, 3) && $past(sclk) != pol;
  endproperty
  property p_oe_span;
    so_oe |-> $past(ce, 4) || $past(ce, 5);
  endproperty
  property p_so_edge;
    so_oe && $past(so_oe) && $changed(so) |-> $past(sclk) != pol && $past(sclk, 6) == pol;
  endproperty
  property p_wk_day7;
    weekly_match |-> $past(cur_time.day) != 3'h7;
  endproperty
  property p_dy_cause;
    s_quiet ##0 (rdy && $changed(daily_match)) |->
      $past(cur_time.hour) != $past(cur_time.hour, 2) || $past(cur_time.minute) != $past(cur_time.minute, 2);
  endproperty
  property p_wk_cause;
    s_quiet ##0 (rdy && $changed(weekly_match)) |-> $past(cur_time) != $past(cur_time, 2);
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("so_oe high while ce low");
  a_oe_drop: assert property (p_oe_drop) else $error("so_oe held after ce fall");
  a_oe_start: assert property (p_oe_start) else $error("so_oe rose without drive edge");
  a_oe_span: assert property (p_oe_span) else $error("so_oe outside session");
  a_so_edge: assert property (p_so_edge) else $error("so moved off drive edge");
  a_wk_day7: assert property (p_wk_day7) else $error("weekly hit on day code 7");
  a_dy_cause: assert property (p_dy_cause) else $error("daily hit moved without time change");
  a_wk_cause: assert property (p_wk_cause) else $error("weekly hit moved without time change");
endmodule
bind rarsp_alarm_port rarsp_checker i_chk (.mclk(mclk), .resetn(resetn), .clk_en(clk_en), .ce(ce),
  .sclk(sclk), .si(si), .cur_time(cur_time), .so(so), .so_oe(so_oe),
  .weekly_match(weekly_match), .daily_match(daily_match));

// ### dv/tb.sv
// tb: register access and alarm compare tests of the alarm port block.
// assumes: host model drives the serial pins; tb drives the rest.
`timescale 1ns/10ps
module tb;
  logic mclk, resetn, clk_en, ce, sclk, si, so, so_oe, weekly_match, daily_match;
  rarsp_pkg::rarsp_time_s cur_time;  // current time to compare
  int         errors;                // mismatches
  int         total_checks;          // comparisons
  logic [7:0] rx;                    // last byte read
  logic [7:0] bv [5] = '{8'h30, 8'h32, 8'h02, 8'h59, 8'h23};  // burst data 8h..ch
  logic [7:0] hv [3] = '{8'h7f, 8'h7f, 8'h3f};                // ffh read back
  ////////////////////////////////////////////////////////////////////////
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  rarsp_alarm_port i_dut (.mclk(mclk), .resetn(resetn), .clk_en(clk_en), .ce(ce), .sclk(sclk),
    .si(si), .cur_time(cur_time), .so(so), .so_oe(so_oe), .weekly_match(weekly_match),
    .daily_match(daily_match));
  rarsp_host_model i_host (.ce(ce), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe));
  ////////////////////////////////////////////////////////////////////////
  // compare tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // open session and send command byte
  task automatic cmd(input logic [3:0] a, input logic [3:0] f, input logic p);
    i_host.open_s(p);
    i_host.shift({a, f}, 8, rx);
  endtask
  // single byte write, sclk high at ce rise
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cmd(a, rarsp_pkg::FMT_WR_SINGLE, 1'b1);
    i_host.shift(d, 8, rx);
    i_host.close_s();
  endtask
  // single byte read, sclk low at ce rise
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    cmd(a, rarsp_pkg::FMT_RD_SINGLE, 1'b0);
    i_host.shift(8'h00, 8, d);
    i_host.close_s();
  endtask
  // set time, check both hits three edges later
  task automatic tm(input logic [2:0] d, input logic [5:0] h, input logic [6:0] m, input logic ew, input logic ed);
    @(posedge mclk) cur_time <= {d, h, m};
    repeat (3) @(posedge mclk);
    #1 chk1(weekly_match, ew);
    chk1(daily_match, ed);
  endtask
  // verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog
  initial
  begin
    repeat (60000) @(posedge mclk);
    errors++;
    test_done();
  end
  // main sequence
  initial
  begin
    errors = 0;
    total_checks = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    cur_time = '0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    for (int i = 0; i < 4; i++)
    begin
      rd(4'(10 + i), rx);
      chk8(rx, 8'h00);
    end
    $display("reset values done");
    for (int i = 0; i < 3; i++)
    begin
      wr(4'(10 + i), 8'hff);
      rd(4'(10 + i), rx);
      chk8(rx, hv[i]);
    end
    $display("unused bits done");
    cmd(4'h8, rarsp_pkg::FMT_WR_BURST, 1'b1);
    foreach (bv[i]) i_host.shift(bv[i], 8, rx);
    i_host.close_s();
    cmd(4'hf, rarsp_pkg::FMT_RD_BURST, 1'b0);
    for (int i = 0; i < 14; i++)
    begin
      i_host.shift(8'h00, 8, rx);
      chk8(rx, (i < 9) ? 8'h00 : bv[i - 9]);
    end
    i_host.close_s();
    $display("burst done");
    tm(3'h1, 6'h32, 7'h30, 1'b1, 1'b0);
    tm(3'h0, 6'h32, 7'h30, 1'b0, 1'b0);
    tm(3'h1, 6'h12, 7'h30, 1'b0, 1'b0);
    tm(3'h7, 6'h23, 7'h59, 1'b0, 1'b1);
    tm(3'h7, 6'h03, 7'h59, 1'b0, 1'b0);
    wr(4'ha, 8'h00);
    tm(3'h1, 6'h32, 7'h30, 1'b0, 1'b0);
    wr(4'ha, 8'h7f);
    for (int d = 0; d < 8; d++) tm(3'(d), 6'h32, 7'h30, 1'(d < 7), 1'b0);
    @(posedge mclk) clk_en <= 1'b0;
    tm(3'h1, 6'h32, 7'h30, 1'b0, 1'b0);
    clk_en <= 1'b1;
    tm(3'h1, 6'h32, 7'h30, 1'b1, 1'b0);
    $display("alarm compare done");
    i_host.open_s(1'b1);
    i_host.shift(8'hb0, 4, rx);
    i_host.close_s();
    cmd(4'hb, rarsp_pkg::FMT_RD_SINGLE, 1'b1);
    i_host.shift(8'h00, 8, rx);
    chk8(rx, 8'h59);
    i_host.shift({4'hb, rarsp_pkg::FMT_WR_SINGLE}, 8, rx);
    i_host.shift(8'h45, 8, rx);
    i_host.close_s();
    rd(4'hb, rx);
    chk8(rx, 8'h45);
    $display("abort and same session done");
    test_done();
  end
endmodule
